// ---- rtl/ssc_pkg.sv ----
// constants, register map and field layout of the clock synchronous serial channel
// Summary of operation
// - mode field picks synchronous operation; any other value idles the channel
// - every frame is exactly eight data bits
// - internal clock is source over 2(n+1), driven out
// - clock select one takes clock from pin
// - transmit needs enable set and buffer loaded
// - receive needs receive enable, transmit enable, loaded buffer
// - transmit interrupt on load or on send end
// - receive interrupt when frame reaches receive buffer
// - overrun when new frame beats buffer read
// - overrun overwrites buffer, receive request unchanged
// - polarity bit selects driving and sampling edge
// - bit order select: bit 0 or 7 first
// - data pin high or floating before first transfer
// - receive-only still shifts dummy data out
// - internal clock out on one of two pins
// - continuous mode: buffer read re-arms reception
package ssc_pkg;
  localparam int unsigned ADDR_W        = 8;
  localparam logic [7:0]  OFS_MODE      = 8'h00;
  localparam logic [7:0]  OFS_CTRL      = 8'h04;
  localparam logic [7:0]  OFS_CTRL2     = 8'h08;
  localparam logic [7:0]  OFS_BRG       = 8'h0C;
  localparam logic [7:0]  OFS_TXBUF     = 8'h10;
  localparam logic [7:0]  OFS_RXBUF     = 8'h14;
  localparam logic [7:0]  OFS_ISTAT     = 8'h18;
  localparam logic [7:0]  OFS_IMASK     = 8'h1C;
  // mode register fields
  localparam int unsigned MODE_SMD_LO   = 0;
  localparam int unsigned MODE_EXT      = 3;
  localparam int unsigned MODE_PSEL_LO  = 4;
  localparam int unsigned MODE_POL      = 6;
  localparam int unsigned MODE_MSB      = 7;
  // control register fields
  localparam int unsigned CTRL_TXEN     = 0;
  localparam int unsigned CTRL_TXEMPTY  = 1;
  localparam int unsigned CTRL_RXEN     = 2;
  localparam int unsigned CTRL_RXFULL   = 3;
  localparam int unsigned CTRL_OD       = 4;
  // control register 2 fields
  localparam int unsigned CTRL2_TXCAUSE = 0;
  localparam int unsigned CTRL2_CONT    = 2;
  localparam int unsigned CTRL2_MULTI   = 4;
  localparam int unsigned CTRL2_ALT     = 5;
  // interrupt status and mask bits
  localparam int unsigned IRQ_TX        = 0;
  localparam int unsigned IRQ_RX        = 1;
  localparam int unsigned IRQ_OVR       = 2;
  localparam int unsigned IRQ_W         = 3;
  // mode field encoding for clock synchronous operation
  localparam logic [2:0]  SMD_SYNC      = 3'h1;
  // count source prescaler terminal counts: f1, f8, f32, f64
  localparam logic [5:0]  PRE_T1        = 6'h00;
  localparam logic [5:0]  PRE_T8        = 6'h07;
  localparam logic [5:0]  PRE_T32       = 6'h1F;
  localparam logic [5:0]  PRE_T64       = 6'h3F;
  localparam logic [2:0]  LAST_BIT      = 3'h7;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_DECERR   = 2'h3;
endpackage : ssc_pkg

// ---- rtl/ssc_top.sv ----
// clock synchronous serial channel with an AXI4-Lite register slave
`timescale 1ns/10ps
module ssc_top (
  // clock and reset
  input  wire logic                      mclk_in,
  input  wire logic                      arst_n_in,
  // axi4-lite write address and data
  input  wire logic                      s_axi_awvalid_in,
  output logic                           s_axi_awready_out,
  input  wire logic [ssc_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic                      s_axi_wvalid_in,
  output logic                           s_axi_wready_out,
  input  wire logic [31:0]               s_axi_wdata_in,
  input  wire logic [3:0]                s_axi_wstrb_in,
  // axi4-lite write response
  output logic                           s_axi_bvalid_out,
  input  wire logic                      s_axi_bready_in,
  output logic [1:0]                     s_axi_bresp_out,
  // axi4-lite read
  input  wire logic                      s_axi_arvalid_in,
  output logic                           s_axi_arready_out,
  input  wire logic [ssc_pkg::ADDR_W-1:0] s_axi_araddr_in,
  output logic                           s_axi_rvalid_out,
  input  wire logic                      s_axi_rready_in,
  output logic [31:0]                    s_axi_rdata_out,
  output logic [1:0]                     s_axi_rresp_out,
  // transfer clock pin, two-way
  input  wire logic                      transfer_clock_pin_in,
  output logic                           transfer_clock_pin_out,
  output logic                           transfer_clock_pin_oe_out,
  // alternate clock output pin
  output logic                           alternate_clock_out_pin_out,
  output logic                           alternate_clock_out_pin_oe_out,
  // serial data pins
  input  wire logic                      serial_data_in_pin_in,
  output logic                           serial_data_out_pin_out,
  output logic                           serial_data_out_pin_oe_out,
  // interrupt
  output logic                           irq_out
);

  typedef struct packed {
    logic [2:0]  smd;
    logic        ext;
    logic [1:0]  psel;
    logic        pol;
    logic        msb;
    logic        tx_en;
    logic        tx_empty;
    logic        rx_en;
    logic        rx_full;
    logic        od;
    logic        tx_cause;
    logic        cont;
    logic        multi;
    logic        alt;
    logic [7:0]  brg;
    logic [7:0]  txbuf;
    logic [7:0]  rxbuf;
    logic [2:0]  sts;
    logic [2:0]  msk;
    logic        busy;
    logic        rx_act;
    logic        armed;
    logic [7:0]  txsh;
    logic [7:0]  rxsh;
    logic [2:0]  bitcnt;
    logic [5:0]  pre;
    logic [7:0]  hcnt;
    logic        lvl;
    logic        sdo;
    logic [2:0]  clk_sy;
    logic [2:0]  din_sy;
    logic        filt;
    logic        din;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  awaddr;
    logic [7:0]  wdata;
    logic        wstb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        tclk_out;
    logic        tclk_oe;
    logic        aclk_out;
    logic        aclk_oe;
    logic        sdo_out;
    logic        sdo_oe;
    logic        irq;
  } ssc_state_t;

  ssc_state_t st_r;
  ssc_state_t st_nxt;
  logic       lead;
  logic       trail;
  logic       done;
  logic       start;
  logic       rd_rx;
  logic       wr_go;
  logic       tick;
  logic       ext_edge;
  logic       sync_md;
  logic       idle;

  function automatic ssc_state_t rst_val();
    rst_val          = '0;
    rst_val.tx_empty = 1'h1;
    rst_val.lvl      = 1'h1;
    rst_val.sdo      = 1'h1;
    rst_val.filt     = 1'h1;
    rst_val.clk_sy   = '1;
    rst_val.awready  = 1'h1;
    rst_val.wready   = 1'h1;
    rst_val.arready  = 1'h1;
    rst_val.tclk_out = 1'h1;
    rst_val.aclk_out = 1'h1;
    rst_val.sdo_out  = 1'h1;
  endfunction : rst_val

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == ssc_pkg::OFS_MODE)  || (a == ssc_pkg::OFS_CTRL)  ||
             (a == ssc_pkg::OFS_CTRL2) || (a == ssc_pkg::OFS_BRG)   ||
             (a == ssc_pkg::OFS_TXBUF) || (a == ssc_pkg::OFS_RXBUF) ||
             (a == ssc_pkg::OFS_ISTAT) || (a == ssc_pkg::OFS_IMASK);
  endfunction : mapped

  // the same shifter serves both directions so send and receive order always match
  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b,
                                          input logic msb);
    shift_in = msb ? {sh[6:0], b} : {b, sh[7:1]};
  endfunction : shift_in

  function automatic logic [31:0] rd_word(input logic [7:0] a, input ssc_state_t s);
    rd_word = 32'h0000_0000;
    unique case (a)
      ssc_pkg::OFS_MODE:  rd_word[7:0] = {s.msb, s.pol, s.psel, s.ext, s.smd};
      ssc_pkg::OFS_CTRL:  rd_word[4:0] = {s.od, s.rx_full, s.rx_en, s.tx_empty, s.tx_en};
      ssc_pkg::OFS_CTRL2: rd_word[5:0] = {s.alt, s.multi, 1'h0, s.cont, 1'h0, s.tx_cause};
      ssc_pkg::OFS_BRG:   rd_word[7:0] = s.brg;
      ssc_pkg::OFS_TXBUF: rd_word[7:0] = s.txbuf;
      ssc_pkg::OFS_RXBUF: rd_word[7:0] = s.rxbuf;
      ssc_pkg::OFS_ISTAT: rd_word[2:0] = s.sts;
      ssc_pkg::OFS_IMASK: rd_word[2:0] = s.msk;
      default:            rd_word = 32'h0000_0000;
    endcase
  endfunction : rd_word

  always_comb begin
    st_nxt   = st_r;
    lead     = 1'h0;
    trail    = 1'h0;
    done     = 1'h0;
    start    = 1'h0;
    rd_rx    = 1'h0;
    sync_md  = (st_r.smd == ssc_pkg::SMD_SYNC);
    idle     = ~st_r.pol;
    // pin inputs pass three flops; a change counts when the last two agree
    st_nxt.clk_sy = {st_r.clk_sy[1:0], transfer_clock_pin_in};
    st_nxt.din_sy = {st_r.din_sy[1:0], serial_data_in_pin_in};
    if (st_r.din_sy[1] == st_r.din_sy[2]) begin
      st_nxt.din = st_r.din_sy[2];
    end
    ext_edge = (st_r.clk_sy[1] == st_r.clk_sy[2]) && (st_r.clk_sy[2] != st_r.filt);
    if (st_r.clk_sy[1] == st_r.clk_sy[2]) begin
      st_nxt.filt = st_r.clk_sy[2];
    end
    // count source prescaler
    unique case (st_r.psel)
      2'h0: tick = (st_r.pre >= ssc_pkg::PRE_T1);
      2'h1: tick = (st_r.pre >= ssc_pkg::PRE_T8);
      2'h2: tick = (st_r.pre >= ssc_pkg::PRE_T32);
      2'h3: tick = (st_r.pre >= ssc_pkg::PRE_T64);
    endcase
    st_nxt.pre = tick ? 6'h00 : 6'(st_r.pre + 6'h01);
    // read channel; a receive buffer read frees it before any frame lands
    if (s_axi_arvalid_in && st_r.arready) begin
      st_nxt.arready = 1'h0;
      st_nxt.rvalid  = 1'h1;
      st_nxt.rresp   = mapped(s_axi_araddr_in) ? ssc_pkg::RESP_OKAY : ssc_pkg::RESP_DECERR;
      st_nxt.rdata   = rd_word(s_axi_araddr_in, st_r);
      rd_rx          = (s_axi_araddr_in == ssc_pkg::OFS_RXBUF);
    end
    if (st_r.rvalid && s_axi_rready_in) begin
      st_nxt.rvalid  = 1'h0;
      st_nxt.arready = 1'h1;
    end
    if (rd_rx) begin
      st_nxt.rx_full = 1'h0;
      if (st_r.cont && st_r.rx_en) begin
        st_nxt.armed = 1'h1;
      end
    end
    // write channels, address and data accepted in either order
    if (s_axi_awvalid_in && st_r.awready) begin
      st_nxt.aw_got  = 1'h1;
      st_nxt.awready = 1'h0;
      st_nxt.awaddr  = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && st_r.wready) begin
      st_nxt.w_got  = 1'h1;
      st_nxt.wready = 1'h0;
      st_nxt.wdata  = s_axi_wdata_in[7:0];
      st_nxt.wstb   = s_axi_wstrb_in[0];
    end
    wr_go = st_r.aw_got && st_r.w_got && !st_r.bvalid;
    if (wr_go) begin
      st_nxt.aw_got = 1'h0;
      st_nxt.w_got  = 1'h0;
      st_nxt.bvalid = 1'h1;
      st_nxt.bresp  = mapped(st_r.awaddr) ? ssc_pkg::RESP_OKAY : ssc_pkg::RESP_DECERR;
      // clear before the engine so a same-cycle event still sets its bit
      if (st_r.wstb && st_r.awaddr == ssc_pkg::OFS_ISTAT) begin
        st_nxt.sts = st_r.sts & ~st_r.wdata[ssc_pkg::IRQ_W-1:0];
      end
    end
    if (st_r.bvalid && s_axi_bready_in) begin
      st_nxt.bvalid  = 1'h0;
      st_nxt.awready = 1'h1;
      st_nxt.wready  = 1'h1;
    end
    // shift engine
    if (!sync_md) begin
      st_nxt.busy = 1'h0;
      st_nxt.sdo  = 1'h1;
      st_nxt.lvl  = idle;
    end else if (!st_r.busy) begin
      st_nxt.lvl = idle;
      if (st_r.tx_en && (!st_r.tx_empty || (st_r.armed && st_r.rx_en)) &&
          (!st_r.ext || st_r.filt == idle)) begin
        start          = 1'h1;
        st_nxt.busy    = 1'h1;
        st_nxt.rx_act  = st_r.rx_en;
        st_nxt.armed   = 1'h0;
        st_nxt.txsh    = st_r.txbuf;
        st_nxt.bitcnt  = 3'h0;
        st_nxt.hcnt    = 8'h00;
        if (!st_r.tx_empty) begin
          st_nxt.tx_empty = 1'h1;
          if (!st_r.tx_cause) begin
            st_nxt.sts[ssc_pkg::IRQ_TX] = 1'h1;
          end
        end
      end
    end else begin
      if (st_r.ext) begin
        lead  = ext_edge && (st_r.filt == idle);
        trail = ext_edge && (st_r.filt != idle);
      end else if (tick) begin
        if (st_r.hcnt == st_r.brg) begin
          st_nxt.hcnt = 8'h00;
          st_nxt.lvl  = ~st_r.lvl;
          lead        = (st_r.lvl == idle);
          trail       = (st_r.lvl != idle);
        end else begin
          st_nxt.hcnt = 8'(st_r.hcnt + 8'h01);
        end
      end
      // leading edge drives, trailing edge samples
      if (lead) begin
        st_nxt.sdo  = st_r.msb ? st_r.txsh[7] : st_r.txsh[0];
        st_nxt.txsh = shift_in(st_r.txsh, 1'h1, st_r.msb);
      end
      if (trail) begin
        st_nxt.rxsh   = shift_in(st_r.rxsh, st_r.din, st_r.msb);
        st_nxt.bitcnt = 3'(st_r.bitcnt + 3'h1);
        if (st_r.bitcnt == ssc_pkg::LAST_BIT) begin
          done        = 1'h1;
          st_nxt.busy = 1'h0;
          if (st_r.tx_cause) begin
            st_nxt.sts[ssc_pkg::IRQ_TX] = 1'h1;
          end
          if (st_r.rx_act) begin
            st_nxt.rxbuf = shift_in(st_r.rxsh, st_r.din, st_r.msb);
            if (st_nxt.rx_full) begin
              st_nxt.sts[ssc_pkg::IRQ_OVR] = 1'h1;
            end else begin
              st_nxt.rx_full              = 1'h1;
              st_nxt.sts[ssc_pkg::IRQ_RX] = 1'h1;
            end
          end
        end
      end
    end
    // register writes land after the engine so a buffer write is never lost
    if (wr_go && st_r.wstb) begin
      unique case (st_r.awaddr)
        ssc_pkg::OFS_MODE: begin
          st_nxt.smd  = st_r.wdata[ssc_pkg::MODE_SMD_LO +: 3];
          st_nxt.ext  = st_r.wdata[ssc_pkg::MODE_EXT];
          st_nxt.psel = st_r.wdata[ssc_pkg::MODE_PSEL_LO +: 2];
          st_nxt.pol  = st_r.wdata[ssc_pkg::MODE_POL];
          st_nxt.msb  = st_r.wdata[ssc_pkg::MODE_MSB];
        end
        ssc_pkg::OFS_CTRL: begin
          st_nxt.tx_en = st_r.wdata[ssc_pkg::CTRL_TXEN];
          st_nxt.rx_en = st_r.wdata[ssc_pkg::CTRL_RXEN];
          st_nxt.od    = st_r.wdata[ssc_pkg::CTRL_OD];
        end
        ssc_pkg::OFS_CTRL2: begin
          st_nxt.tx_cause = st_r.wdata[ssc_pkg::CTRL2_TXCAUSE];
          st_nxt.cont     = st_r.wdata[ssc_pkg::CTRL2_CONT];
          st_nxt.multi    = st_r.wdata[ssc_pkg::CTRL2_MULTI];
          st_nxt.alt      = st_r.wdata[ssc_pkg::CTRL2_ALT];
        end
        ssc_pkg::OFS_BRG:   st_nxt.brg = st_r.wdata;
        ssc_pkg::OFS_TXBUF: begin
          st_nxt.txbuf    = st_r.wdata;
          st_nxt.tx_empty = 1'h0;
        end
        ssc_pkg::OFS_IMASK: st_nxt.msk = st_r.wdata[ssc_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
    // pins; the second clock pin only works with the internal clock
    st_nxt.tclk_out = st_nxt.lvl;
    st_nxt.aclk_out = st_nxt.lvl;
    st_nxt.tclk_oe  = (st_nxt.smd == ssc_pkg::SMD_SYNC) && !st_nxt.ext &&
                      !(st_nxt.multi && st_nxt.alt);
    st_nxt.aclk_oe  = (st_nxt.smd == ssc_pkg::SMD_SYNC) && !st_nxt.ext &&
                      st_nxt.multi && st_nxt.alt;
    st_nxt.sdo_out  = st_nxt.sdo;
    st_nxt.sdo_oe   = (st_nxt.smd == ssc_pkg::SMD_SYNC) && (!st_nxt.od || !st_nxt.sdo);
    st_nxt.irq      = |(st_nxt.sts & st_nxt.msk);
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r <= rst_val();
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready_out              = st_r.awready;
  assign s_axi_wready_out               = st_r.wready;
  assign s_axi_bvalid_out               = st_r.bvalid;
  assign s_axi_bresp_out                = st_r.bresp;
  assign s_axi_arready_out              = st_r.arready;
  assign s_axi_rvalid_out               = st_r.rvalid;
  assign s_axi_rdata_out                = st_r.rdata;
  assign s_axi_rresp_out                = st_r.rresp;
  assign transfer_clock_pin_out         = st_r.tclk_out;
  assign transfer_clock_pin_oe_out      = st_r.tclk_oe;
  assign alternate_clock_out_pin_out    = st_r.aclk_out;
  assign alternate_clock_out_pin_oe_out = st_r.aclk_oe;
  assign serial_data_out_pin_out        = st_r.sdo_out;
  assign serial_data_out_pin_oe_out     = st_r.sdo_oe;
  assign irq_out                        = st_r.irq;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);

  a_tx_start_cond: assert property ($rose(st_r.busy) |->
    $past(st_r.tx_en) && $past(st_r.smd) == ssc_pkg::SMD_SYNC) else $error("start without enable");
  a_rx_needs_tx: assert property ($rose(st_r.rx_act) |-> $past(st_r.tx_en))
    else $error("reception started without transmit enable");
  a_frame_eight: assert property ($fell(st_r.busy) && st_r.smd == ssc_pkg::SMD_SYNC |->
    $past(st_r.bitcnt) == ssc_pkg::LAST_BIT) else $error("frame not eight bits");
  a_half_period: assert property (st_r.busy && !st_r.ext && $changed(st_r.lvl) |->
    $past(st_r.hcnt) == $past(st_r.brg)) else $error("half period wrong");
  a_ext_no_drive: assert property (st_r.ext |-> !transfer_clock_pin_oe_out &&
    !alternate_clock_out_pin_oe_out) else $error("clock driven in external mode");
  a_load_irq: assert property (start && !st_r.tx_empty && !st_r.tx_cause |=>
    st_r.sts[ssc_pkg::IRQ_TX] && st_r.tx_empty) else $error("load did not flag");
  a_overrun_flag: assert property (done && st_r.rx_act && st_r.rx_full && !rd_rx |=>
    st_r.sts[ssc_pkg::IRQ_OVR]) else $error("overrun missed");
  a_rx_deliver: assert property (done && st_r.rx_act && (!st_r.rx_full || rd_rx) |=>
    st_r.rx_full && st_r.sts[ssc_pkg::IRQ_RX]) else $error("frame not delivered");
  a_clk_mux: assert property (alternate_clock_out_pin_oe_out |->
    st_r.multi && st_r.alt && !transfer_clock_pin_oe_out) else $error("both clock pins on");
  a_cont_rearm: assert property (rd_rx && st_r.cont && st_r.rx_en && !start |=>
    st_r.armed || st_r.busy) else $error("continuous receive not re-armed");

endmodule : ssc_top

// ---- test/ssc_peer.sv ----
// far-side serial peer: trades one byte a frame and can source the transfer clock
`timescale 1ns/10ps
module ssc_peer (
  // system clock
  input  wire logic        mclk_in,
  // serial wires
  input  wire logic        sck_in,
  input  wire logic        sdo_in,
  output logic             sdi_out,
  output logic             eck_out,
  // bench control
  input  wire logic        pol_in,
  input  wire logic        msb_in,
  input  wire logic        go_in,
  input  wire logic        clr_in,
  input  wire logic [7:0]  byte_in,
  output logic [7:0]       got_out,
  output logic [3:0]       cnt_out,
  output logic [15:0]      per_out
);
  logic [15:0] cyc  = 16'h0000;
  logic [15:0] last = 16'h0000;
  logic [3:0]  lead = 4'h0;
  logic        sq   = 1'b1;
  int          tog  = 0;
  int          div  = 0;
  initial sdi_out = 1'b0;
  initial eck_out = 1'b1;
  // edges are seen one system clock late, which a real part would also tolerate
  always @(posedge mclk_in) begin
    sq  <= sck_in;
    cyc <= cyc + 16'h0001;
    if (sck_in != sq && sck_in == pol_in) begin
      sdi_out <= byte_in[msb_in ? 3'h7 - lead[2:0] : lead[2:0]];
      lead    <= lead + 4'h1;
      per_out <= cyc - last;
      last    <= cyc;
    end else if (sck_in != sq) begin
      got_out <= msb_in ? {got_out[6:0], sdo_in} : {sdo_in, got_out[7:1]};
      cnt_out <= cnt_out + 4'h1;
    end else if (cnt_out == 4'h8 || lead == 4'h0) sdi_out <= ~sdi_out;
    // clock stands at idle level outside frames, half period of eight clocks
    if (go_in && tog == 0) tog <= 16;
    if (tog == 0) eck_out <= ~pol_in;
    else if (div == 7) begin
      eck_out <= ~eck_out;
      tog     <= tog - 1;
      div     <= 0;
    end else div <= div + 1;
    if (clr_in) begin
      lead    <= 4'h0;
      cnt_out <= 4'h0;
      got_out <= 8'h00;
    end
  end
endmodule : ssc_peer

// ---- test/tb_sync_serial_channel_mode.sv ----
// self-checking bench for the clock synchronous serial channel
`timescale 1ns/10ps
module tb_sync_serial_channel_mode;
  logic        mclk_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic        aw_v = 1'b0, w_v = 1'b0, ar_v = 1'b0, pclr = 1'b0, go = 1'b0;
  logic        pol = 1'b0, msb = 1'b0;
  logic [7:0]  aw_a = 8'h00, ar_a = 8'h00, pb = 8'h00;
  logic [31:0] w_d = 32'h0, r_d;
  logic        aw_r, w_r, b_v, ar_r, r_v, ck_o, ck_oe, alt_o, alt_oe, sd_o, sd_oe, irq;
  logic        sdi, eck, ck_w, sck, sd_w;
  logic [1:0]  r_rs, b_rs, rsp;
  logic [7:0]  got;
  logic [3:0]  cnt;
  logic [15:0] per;
  int          fails = 0, cmp_count = 0, cyc = 0;
  always #12.5 mclk_in = ~mclk_in;
  assign ck_w = ck_oe ? ck_o : eck;
  assign sck  = alt_oe ? alt_o : ck_w;
  // pull-up keeps the released open-drain data line high
  assign sd_w = sd_oe ? sd_o : 1'b1;
  ssc_top DUT (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
    .s_axi_awvalid_in(aw_v), .s_axi_awready_out(aw_r), .s_axi_awaddr_in(aw_a),
    .s_axi_wvalid_in(w_v), .s_axi_wready_out(w_r), .s_axi_wdata_in(w_d),
    .s_axi_wstrb_in(4'hF), .s_axi_bvalid_out(b_v), .s_axi_bready_in(1'b1),
    .s_axi_bresp_out(b_rs), .s_axi_arvalid_in(ar_v), .s_axi_arready_out(ar_r),
    .s_axi_araddr_in(ar_a), .s_axi_rvalid_out(r_v), .s_axi_rready_in(1'b1),
    .s_axi_rdata_out(r_d), .s_axi_rresp_out(r_rs), .transfer_clock_pin_in(ck_w),
    .transfer_clock_pin_out(ck_o), .transfer_clock_pin_oe_out(ck_oe),
    .alternate_clock_out_pin_out(alt_o), .alternate_clock_out_pin_oe_out(alt_oe),
    .serial_data_in_pin_in(sdi), .serial_data_out_pin_out(sd_o),
    .serial_data_out_pin_oe_out(sd_oe), .irq_out(irq));
  ssc_peer PEER (.mclk_in(mclk_in), .sck_in(sck), .sdo_in(sd_w), .sdi_out(sdi),
    .eck_out(eck), .pol_in(pol), .msb_in(msb), .go_in(go), .clr_in(pclr),
    .byte_in(pb), .got_out(got), .cnt_out(cnt), .per_out(per));
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    aw_v <= 1'b1;
    aw_a <= a;
    w_v  <= 1'b1;
    w_d  <= d;
    do begin
      @(posedge mclk_in);
      if (aw_r) aw_v <= 1'b0;
      if (w_r) w_v <= 1'b0;
    end while (!b_v);
    rsp = b_rs;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    ar_v <= 1'b1;
    ar_a <= a;
    do begin
      @(posedge mclk_in);
      if (ar_r) ar_v <= 1'b0;
    end while (!r_v);
    d   = r_d;
    rsp = r_rs;
  endtask : rd
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(n, e, d);
  endtask : rdc
  task automatic pclear(input logic [7:0] b);
    pb   <= b;
    pclr <= 1'b1;
    @(posedge mclk_in);
    pclr <= 1'b0;
  endtask : pclear
  // bounded wait for eight trailing edges, then room for the buffer update
  task automatic wait_end();
    int t;
    t = 0;
    while (cnt !== 4'h8 && t < 3000) begin
      @(posedge mclk_in);
      t++;
    end
    repeat (8) @(posedge mclk_in);
  endtask : wait_end
  // data-in crosses a three-flop synchroniser, so receive frames need n of five or more
  task automatic frame(input logic [7:0] md, c2, ct, n, tx, b, input bit rx);
    logic [31:0] d;
    pol <= md[6];
    msb <= md[7];
    wr(ssc_pkg::OFS_ISTAT, 32'h7);
    wr(ssc_pkg::OFS_MODE, {24'h0, md});
    wr(ssc_pkg::OFS_CTRL2, {24'h0, c2});
    wr(ssc_pkg::OFS_BRG, {24'h0, n});
    wr(ssc_pkg::OFS_CTRL, {24'h0, ct});
    pclear(b);
    wr(ssc_pkg::OFS_TXBUF, {24'h0, tx});
    if (md[3]) begin
      go <= 1'b1;
      @(posedge mclk_in);
      go <= 1'b0;
    end
    repeat (4) @(posedge mclk_in);
    rd(ssc_pkg::OFS_ISTAT, d);
    chk("tx irq mid frame", {31'h0, ~c2[0]}, {31'h0, d[0]});
    wait_end();
    chk("peer byte", {24'h0, tx}, {24'h0, got});
    if (!md[3]) chk("clock period", 2 * ({24'h0, n} + 32'h1), {16'h0, per});
    chk("clock idle", {31'h0, ~md[6]}, {31'h0, sck});
    if (rx) rdc("rx buffer", ssc_pkg::OFS_RXBUF, {24'h0, b});
  endtask : frame
  task automatic t_reset();
    logic [31:0] d;
    rdc("ctrl reset", ssc_pkg::OFS_CTRL, 32'h2);
    rd(8'h40, d);
    chk("unmapped resp", {30'h0, ssc_pkg::RESP_DECERR}, {30'h0, rsp});
    wr(8'h40, 32'h0);
    chk("unmapped wr resp", {30'h0, ssc_pkg::RESP_DECERR}, {30'h0, rsp});
    wr(ssc_pkg::OFS_MODE, 32'h1);
    chk("mapped wr resp", {30'h0, ssc_pkg::RESP_OKAY}, {30'h0, rsp});
    wr(ssc_pkg::OFS_CTRL, 32'h10);
    repeat (3) @(posedge mclk_in);
    chk("open drain idle", 32'h0, {31'h0, sd_oe});
    wr(ssc_pkg::OFS_CTRL, 32'h0);
    repeat (3) @(posedge mclk_in);
    chk("data idle", 32'h1, {31'h0, sd_w});
    wr(ssc_pkg::OFS_IMASK, 32'h7);
  endtask : t_reset
  task automatic t_frames();
    frame(8'h01, 8'h01, 8'h05, 8'h06, 8'hA5, 8'h3C, 1'b1);
    rdc("status send end", ssc_pkg::OFS_ISTAT, 32'h3);
    rdc("ctrl after load", ssc_pkg::OFS_CTRL, 32'h7);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(ssc_pkg::OFS_ISTAT, 32'h7);
    repeat (2) @(posedge mclk_in);
    chk("irq cleared", 32'h0, {31'h0, irq});
    frame(8'hC1, 8'h00, 8'h05, 8'h05, 8'h1E, 8'hB4, 1'b1);
    rdc("status on load", ssc_pkg::OFS_ISTAT, 32'h3);
    frame(8'h89, 8'h00, 8'h05, 8'h00, 8'h96, 8'h69, 1'b1);
    chk("clock pin released", 32'h0, {31'h0, ck_oe});
  endtask : t_frames
  task automatic t_alt();
    frame(8'h01, 8'h31, 8'h05, 8'h05, 8'h5C, 8'hC5, 1'b1);
    chk("alt pin driven", 32'h1, {31'h0, alt_oe});
    chk("main pin released", 32'h0, {31'h0, ck_oe});
    wr(ssc_pkg::OFS_MODE, 32'h9);
    repeat (3) @(posedge mclk_in);
    chk("alt pin with ext", 32'h0, {31'h0, alt_oe});
  endtask : t_alt
  task automatic t_gate();
    wr(ssc_pkg::OFS_MODE, 32'h0);
    wr(ssc_pkg::OFS_CTRL, 32'h5);
    pclear(8'h00);
    wr(ssc_pkg::OFS_TXBUF, 32'h3A);
    repeat (40) @(posedge mclk_in);
    chk("no frame mode off", 32'h0, {28'h0, cnt});
    chk("data high mode off", 32'h1, {31'h0, sd_w});
    wr(ssc_pkg::OFS_CTRL, 32'h4);
    wr(ssc_pkg::OFS_MODE, 32'h1);
    repeat (40) @(posedge mclk_in);
    chk("no frame tx off", 32'h0, {28'h0, cnt});
    wr(ssc_pkg::OFS_CTRL, 32'h5);
    wait_end();
    chk("held byte sent", 32'h3A, {24'h0, got});
  endtask : t_gate
  task automatic t_overrun();
    frame(8'h01, 8'h01, 8'h05, 8'h03, 8'h11, 8'h22, 1'b0);
    frame(8'h01, 8'h01, 8'h05, 8'h05, 8'h33, 8'h44, 1'b0);
    rdc("overrun status", ssc_pkg::OFS_ISTAT, 32'h5);
    wr(ssc_pkg::OFS_IMASK, 32'h2);
    repeat (2) @(posedge mclk_in);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(ssc_pkg::OFS_IMASK, 32'h4);
    repeat (2) @(posedge mclk_in);
    chk("irq overrun", 32'h1, {31'h0, irq});
    wr(ssc_pkg::OFS_IMASK, 32'h7);
    frame(8'h01, 8'h01, 8'h01, 8'h01, 8'h77, 8'h88, 1'b0);
    rdc("tx only status", ssc_pkg::OFS_ISTAT, 32'h1);
    rdc("rx overwritten", ssc_pkg::OFS_RXBUF, 32'h44);
  endtask : t_overrun
  task automatic t_cont();
    frame(8'h01, 8'h05, 8'h05, 8'h05, 8'hC3, 8'h5A, 1'b0);
    pclear(8'h6B);
    rdc("cont first", ssc_pkg::OFS_RXBUF, 32'h5A);
    wait_end();
    chk("dummy resent", 32'hC3, {24'h0, got});
    wr(ssc_pkg::OFS_CTRL2, 32'h1);
    rdc("cont second", ssc_pkg::OFS_RXBUF, 32'h6B);
  endtask : t_cont
  // whole run needs well under ten thousand clocks
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    repeat (12) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    t_reset();
    t_frames();
    t_alt();
    t_gate();
    t_overrun();
    t_cont();
    finish_test();
  end
endmodule : tb_sync_serial_channel_mode
